// ===== hdl/pscio_consts.svh
// Constants of the scan-cycle I/O refresh engine
// Functional notes
// - Before each scan, sample all input terminals at once into the input image.
// - After the end instruction, copy the output image to the output terminals in one batch.
// - Input contacts read the input image, never the live terminal.
// - Output contacts read the output image, seeing results written earlier this scan.
// - Output coils write only the output image; terminals change at next refresh.
// - Input change reaches outputs after one to two scans.
// - Time each end-to-end interval in 10 ms units into special words.
// - Keep minimum, present and maximum scan time words, updated every scan.
// - Scan time accuracy is plus or minus one 10 ms unit.
// - Word registers are 16 bits, binary weighted, top bit is the sign.
// - Signed words hold -32768 through 32767.
// - As hexadecimal, words hold zero through all ones.
// - Input image has 64 bits, 12 backed by terminals.
// - Output image has 64 bits, 7 drive terminals at output refresh.
// - Sixteen timers: 100 ms, 10 ms or 100 ms retentive.
// - Sixteen up counters with set values 1 to 32767; no interrupt counters.
// - 256 special relays and 256 special words, only a few functional.
// - Latch-assignable relays still clear at power-on or reset.
// - Image refresh continues in both run and stop states.
`ifndef PSCIO_CONSTS_SVH
`define PSCIO_CONSTS_SVH

`define PSCIO_CLK_NS        50
`define PSCIO_TICK_NS       10000000
`define PSCIO_TICK_CYCLES   (`PSCIO_TICK_NS / `PSCIO_CLK_NS)
`define PSCIO_TMR100_DIV    4'h9
`define PSCIO_X_INST        12
`define PSCIO_Y_INST        7
`define PSCIO_TC_POINTS     16
`define PSCIO_D_POINTS      160
`define PSCIO_WORD_MAX      16'h7FFF
`define PSCIO_SW_MIN_IDX    8'h11
`define PSCIO_SW_PRES_IDX   8'h12
`define PSCIO_SW_MAX_IDX    8'h13
`define PSCIO_SM_RUN_IDX    8'h00

`define PSCIO_REG_CTRL      8'h00
`define PSCIO_REG_STATUS    8'h04
`define PSCIO_REG_TMODE     8'h08
`define PSCIO_REG_SCAN_MIN  8'h0C
`define PSCIO_REG_SCAN_PRES 8'h10
`define PSCIO_REG_SCAN_MAX  8'h14
`define PSCIO_REG_IN_IMAGE  8'h18
`define PSCIO_REG_OUT_TERM  8'h1C
`define PSCIO_REG_LAST      8'h1C
`define PSCIO_CTRL_RST      1'h1
`define PSCIO_TMODE_RST     32'h0000_0000
`define PSCIO_RESP_OKAY     2'h0
`define PSCIO_RESP_SLVERR   2'h2

`endif

// ===== hdl/pscio_pkg.sv
// Types of the scan-cycle I/O refresh engine
package pscio_pkg;
  typedef logic signed [15:0] pscio_word_t;
  typedef enum logic [3:0] {
    OP_RD_SD = 4'h0, OP_LD_X = 4'h1, OP_LD_Y = 4'h2, OP_LD_M = 4'h3,
    OP_LD_T = 4'h4, OP_LD_C = 4'h5, OP_LD_SM = 4'h6, OP_OUT_Y = 4'h7,
    OP_OUT_M = 4'h8, OP_OUT_T = 4'h9, OP_OUT_C = 4'hA, OP_RST_T = 4'hB,
    OP_RST_C = 4'hC, OP_RD_D = 4'hD, OP_WR_D = 4'hE, OP_END = 4'hF
  } pscio_op_t;
  typedef enum logic [3:0] {
    ST_IN_REFRESH = 4'b0001, ST_EXEC = 4'b0010, ST_END_PROC = 4'b0100, ST_OUT_REFRESH = 4'b1000
  } pscio_state_t;
  typedef enum logic [1:0] {
    TM_100MS = 2'h0, TM_10MS = 2'h1, TM_RET = 2'h2, TM_SPARE = 2'h3
  } pscio_tmode_t;
endpackage : pscio_pkg

// ===== hdl/pscio_reg_if.sv
// Register access carrier between bus slave and engine core
`timescale 1ns/1ps
interface pscio_reg_if;
  logic        wr_en;
  logic [7:0]  wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic [7:0]  rd_addr;
  logic [31:0] rd_data;
  modport axi  (output wr_en, wr_addr, wr_data, wr_strb, rd_addr, input rd_data);
  modport core (input wr_en, wr_addr, wr_data, wr_strb, rd_addr, output rd_data);
endinterface : pscio_reg_if

// ===== hdl/pscio_scantime.sv
// Scan time measurement in 10 ms units
`timescale 1ns/1ps
`include "pscio_consts.svh"
module pscio_scantime (
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  input  wire logic        i_tick,
  input  wire logic        i_end,
  output logic [15:0]      o_min,
  output logic [15:0]      o_present,
  output logic [15:0]      o_max,
  output logic             o_seeded
);
  logic [15:0] ticks;
  wire  [15:0] sample = (i_tick && ticks != `PSCIO_WORD_MAX) ? ticks + 16'h0001 : ticks;

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ticks     <= 16'h0000;
      o_min     <= 16'h0000;
      o_present <= 16'h0000;
      o_max     <= 16'h0000;
      o_seeded  <= 1'b0;
    end else if (i_end) begin
      ticks     <= 16'h0000;
      o_present <= sample;
      o_seeded  <= 1'b1;
      o_min     <= (!o_seeded || sample < o_min) ? sample : o_min;
      o_max     <= (!o_seeded || sample > o_max) ? sample : o_max;
    end else begin
      ticks <= sample;
    end
  end
endmodule : pscio_scantime

// ===== hdl/pscio_axil.sv
// AXI4-Lite slave for the engine registers
`timescale 1ns/1ps
`include "pscio_consts.svh"
module pscio_axil (
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  input  wire logic [7:0]  i_awaddr,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  output logic             o_bvalid,
  output logic [1:0]       o_bresp,
  input  wire logic        i_bready,
  input  wire logic [7:0]  i_araddr,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  output logic             o_rvalid,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  input  wire logic        i_rready,
  pscio_reg_if.axi         rif
);
  function automatic logic pscio_addr_ok(input logic [7:0] a);
    pscio_addr_ok = (a[1:0] == 2'h0) && (a <= `PSCIO_REG_LAST);
  endfunction : pscio_addr_ok

  logic        aw_got;
  logic        w_got;
  logic        rd_pend;
  logic [7:0]  aw_q;
  logic [7:0]  ar_q;
  logic [31:0] wd_q;
  logic [3:0]  ws_q;
  wire         aw_take = i_awvalid & o_awready;
  wire         w_take  = i_wvalid & o_wready;
  wire         ar_take = i_arvalid & o_arready;

  assign rif.wr_addr = aw_q;
  assign rif.wr_data = wd_q;
  assign rif.wr_strb = ws_q;
  assign rif.rd_addr = ar_q;

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_awready <= 1'b1;
      o_wready  <= 1'b1;
      o_bvalid  <= 1'b0;
      o_bresp   <= `PSCIO_RESP_OKAY;
      aw_got    <= 1'b0;
      w_got     <= 1'b0;
      aw_q      <= 8'h00;
      wd_q      <= 32'h0000_0000;
      ws_q      <= 4'h0;
      rif.wr_en <= 1'b0;
    end else begin
      rif.wr_en <= 1'b0;
      if (aw_take) begin
        aw_q      <= i_awaddr;
        aw_got    <= 1'b1;
        o_awready <= 1'b0;
      end
      if (w_take) begin
        wd_q     <= i_wdata;
        ws_q     <= i_wstrb;
        w_got    <= 1'b1;
        o_wready <= 1'b0;
      end
      if (aw_got && w_got && !o_bvalid) begin
        rif.wr_en <= pscio_addr_ok(aw_q);
        o_bresp   <= pscio_addr_ok(aw_q) ? `PSCIO_RESP_OKAY : `PSCIO_RESP_SLVERR;
        o_bvalid  <= 1'b1;
        aw_got    <= 1'b0;
        w_got     <= 1'b0;
      end
      if (o_bvalid && i_bready) begin
        o_bvalid  <= 1'b0;
        o_awready <= 1'b1;
        o_wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_arready <= 1'b1;
      o_rvalid  <= 1'b0;
      o_rdata   <= 32'h0000_0000;
      o_rresp   <= `PSCIO_RESP_OKAY;
      rd_pend   <= 1'b0;
      ar_q      <= 8'h00;
    end else begin
      if (ar_take) begin
        ar_q      <= i_araddr;
        rd_pend   <= 1'b1;
        o_arready <= 1'b0;
      end
      if (rd_pend) begin
        o_rdata  <= pscio_addr_ok(ar_q) ? rif.rd_data : 32'h0000_0000;
        o_rresp  <= pscio_addr_ok(ar_q) ? `PSCIO_RESP_OKAY : `PSCIO_RESP_SLVERR;
        o_rvalid <= 1'b1;
        rd_pend  <= 1'b0;
      end
      if (o_rvalid && i_rready) begin
        o_rvalid  <= 1'b0;
        o_arready <= 1'b1;
      end
    end
  end
endmodule : pscio_axil

// ===== hdl/pscio_top.sv
// Scan-cycle engine with batch input and output image refresh
`timescale 1ns/1ps
`include "pscio_consts.svh"
module pscio_top #(
  parameter int unsigned TICK_CYCLES = `PSCIO_TICK_CYCLES
) (
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  input  wire logic [7:0]  i_axi_awaddr,
  input  wire logic        i_axi_awvalid,
  output logic             o_axi_awready,
  input  wire logic [31:0] i_axi_wdata,
  input  wire logic [3:0]  i_axi_wstrb,
  input  wire logic        i_axi_wvalid,
  output logic             o_axi_wready,
  output logic             o_axi_bvalid,
  output logic [1:0]       o_axi_bresp,
  input  wire logic        i_axi_bready,
  input  wire logic [7:0]  i_axi_araddr,
  input  wire logic        i_axi_arvalid,
  output logic             o_axi_arready,
  output logic             o_axi_rvalid,
  output logic [31:0]      o_axi_rdata,
  output logic [1:0]       o_axi_rresp,
  input  wire logic        i_axi_rready,
  input  wire logic [11:0] i_term_in,
  output logic [6:0]       o_term_out,
  input  wire logic        i_op_valid,
  input  wire logic [3:0]  i_op_code,
  input  wire logic [7:0]  i_op_addr,
  input  wire logic        i_op_bit,
  input  wire logic [15:0] i_op_word,
  output logic             o_op_ready,
  output logic             o_op_done,
  output logic             o_op_bit,
  output logic [15:0]      o_op_word,
  output logic             o_running
);
  localparam logic [17:0] TICK_LAST = 18'(TICK_CYCLES - 1);

  // any nonzero 16-bit pattern is reached the same; a zero set value is never reached
  function automatic logic pscio_reached(input logic [15:0] pv, input logic [15:0] setv);
    pscio_reached = (setv != 16'h0000) && (pv >= setv);
  endfunction : pscio_reached

  function automatic logic [15:0] pscio_tmr_next(input logic [15:0] pv, input logic coil,
                                                 input logic [1:0] mode, input logic [15:0] el10,
                                                 input logic [15:0] el100);
    logic [16:0] sum;
    logic [15:0] step;
    step = (mode == pscio_pkg::TM_10MS) ? el10 : el100;
    sum  = {1'b0, pv} + {1'b0, step};
    if (!coil) begin
      pscio_tmr_next = (mode == pscio_pkg::TM_RET) ? pv : 16'h0000;
    end else if (sum > {1'b0, `PSCIO_WORD_MAX}) begin
      pscio_tmr_next = `PSCIO_WORD_MAX;
    end else begin
      pscio_tmr_next = sum[15:0];
    end
  endfunction : pscio_tmr_next

  pscio_reg_if rif ();

  pscio_pkg::pscio_state_t state;
  pscio_pkg::pscio_state_t next_state;
  logic [17:0]             tick_cnt;
  logic                    tick;
  logic [3:0]              div100;
  logic [15:0]             el100;
  logic                    run_en;
  logic [31:0]             tmode;
  logic [63:0]             in_image;
  logic [63:0]             out_image;
  logic [63:0]             relay;
  // plain 16-bit words, top bit is the sign
  logic [15:0]             data_mem [0:`PSCIO_D_POINTS-1];
  logic [15:0]             tmr_pv   [0:`PSCIO_TC_POINTS-1];
  logic [15:0]             tmr_set  [0:`PSCIO_TC_POINTS-1];
  logic [15:0]             cnt_pv   [0:`PSCIO_TC_POINTS-1];
  logic [15:0]             cnt_set  [0:`PSCIO_TC_POINTS-1];
  logic [15:0]             tmr_pv_next [0:`PSCIO_TC_POINTS-1];
  logic [15:0]             cnt_pv_next [0:`PSCIO_TC_POINTS-1];
  logic [15:0]             tmr_coil;
  logic [15:0]             tmr_done;
  logic [15:0]             cnt_coil;
  logic [15:0]             cnt_prev;
  logic [15:0]             cnt_done;
  logic [15:0]             scan_min;
  logic [15:0]             scan_pres;
  logic [15:0]             scan_max;
  logic                    seeded;
  logic [15:0]             sp_word;
  logic                    sp_bit;
  logic                    res_bit;
  logic [15:0]             res_word;

  wire       op_take  = i_op_valid & o_op_ready;
  wire       op_end   = op_take && (i_op_code == pscio_pkg::OP_END);
  wire [5:0] bit_idx  = i_op_addr[5:0];
  wire [3:0] tc_idx   = i_op_addr[3:0];
  wire       d_ok     = i_op_addr < 8'(`PSCIO_D_POINTS);
  wire       reg_wr   = rif.wr_en;
  wire       wr_ctrl  = reg_wr && (rif.wr_addr == `PSCIO_REG_CTRL);
  wire       wr_tmode = reg_wr && (rif.wr_addr == `PSCIO_REG_TMODE);
  wire       st_in    = (state == pscio_pkg::ST_IN_REFRESH);
  wire       st_end   = (state == pscio_pkg::ST_END_PROC);
  wire       st_out   = (state == pscio_pkg::ST_OUT_REFRESH);

  pscio_axil u_axil (
    .i_clk     (i_clk),
    .i_nrst    (i_nrst),
    .i_awaddr  (i_axi_awaddr),
    .i_awvalid (i_axi_awvalid),
    .o_awready (o_axi_awready),
    .i_wdata   (i_axi_wdata),
    .i_wstrb   (i_axi_wstrb),
    .i_wvalid  (i_axi_wvalid),
    .o_wready  (o_axi_wready),
    .o_bvalid  (o_axi_bvalid),
    .o_bresp   (o_axi_bresp),
    .i_bready  (i_axi_bready),
    .i_araddr  (i_axi_araddr),
    .i_arvalid (i_axi_arvalid),
    .o_arready (o_axi_arready),
    .o_rvalid  (o_axi_rvalid),
    .o_rdata   (o_axi_rdata),
    .o_rresp   (o_axi_rresp),
    .i_rready  (i_axi_rready),
    .rif       (rif.axi)
  );

  pscio_scantime u_scan (
    .i_clk     (i_clk),
    .i_nrst    (i_nrst),
    .i_tick    (tick),
    .i_end     (op_end),
    .o_min     (scan_min),
    .o_present (scan_pres),
    .o_max     (scan_max),
    .o_seeded  (seeded)
  );

  // only a few special points carry a function
  assign sp_word = (i_op_addr == `PSCIO_SW_MIN_IDX)  ? scan_min  :
                   (i_op_addr == `PSCIO_SW_PRES_IDX) ? scan_pres :
                   (i_op_addr == `PSCIO_SW_MAX_IDX)  ? scan_max  : 16'h0000;
  assign sp_bit  = (i_op_addr == `PSCIO_SM_RUN_IDX) && run_en;

  // input contacts come from the image
  // output contacts come from the image
  assign res_bit = (i_op_code == pscio_pkg::OP_LD_X)  ? in_image[bit_idx]  :
                   (i_op_code == pscio_pkg::OP_LD_Y)  ? out_image[bit_idx] :
                   (i_op_code == pscio_pkg::OP_LD_M)  ? relay[bit_idx]     :
                   (i_op_code == pscio_pkg::OP_LD_T)  ? tmr_done[tc_idx]   :
                   (i_op_code == pscio_pkg::OP_LD_C)  ? cnt_done[tc_idx]   :
                   (i_op_code == pscio_pkg::OP_LD_SM) ? sp_bit             : 1'b0;
  assign res_word = (i_op_code == pscio_pkg::OP_RD_SD) ? sp_word :
                    (i_op_code == pscio_pkg::OP_RD_D && d_ok) ? data_mem[i_op_addr] : 16'h0000;

  assign rif.rd_data =
    (rif.rd_addr == `PSCIO_REG_CTRL)      ? {31'h0000_0000, run_en} :
    (rif.rd_addr == `PSCIO_REG_STATUS)    ? {26'h000_0000, seeded, state, run_en} :
    (rif.rd_addr == `PSCIO_REG_TMODE)     ? tmode :
    (rif.rd_addr == `PSCIO_REG_SCAN_MIN)  ? {16'h0000, scan_min} :
    (rif.rd_addr == `PSCIO_REG_SCAN_PRES) ? {16'h0000, scan_pres} :
    (rif.rd_addr == `PSCIO_REG_SCAN_MAX)  ? {16'h0000, scan_max} :
    (rif.rd_addr == `PSCIO_REG_IN_IMAGE)  ? {20'h0_0000, in_image[11:0]} :
    (rif.rd_addr == `PSCIO_REG_OUT_TERM)  ? {25'h000_0000, o_term_out} : 32'h0000_0000;

  // refresh runs in run and stop alike
  always_comb begin
    case (state)
      pscio_pkg::ST_IN_REFRESH:  next_state = pscio_pkg::ST_EXEC;
      pscio_pkg::ST_EXEC: begin
        if (op_end) begin
          next_state = pscio_pkg::ST_END_PROC;
        end else if (!run_en) begin
          next_state = pscio_pkg::ST_OUT_REFRESH;
        end else begin
          next_state = pscio_pkg::ST_EXEC;
        end
      end
      pscio_pkg::ST_END_PROC:    next_state = pscio_pkg::ST_OUT_REFRESH;
      pscio_pkg::ST_OUT_REFRESH: next_state = pscio_pkg::ST_IN_REFRESH;
      default:                   next_state = pscio_pkg::ST_IN_REFRESH;
    endcase
  end

  // timer and counter present values at end processing
  always_comb begin
    for (int k = 0; k < `PSCIO_TC_POINTS; k++) begin
      tmr_pv_next[k] = pscio_tmr_next(tmr_pv[k], tmr_coil[k], tmode[2*k +: 2], scan_pres, el100);
      cnt_pv_next[k] = (cnt_coil[k] && !cnt_prev[k] && cnt_pv[k] < cnt_set[k]) ?
                       cnt_pv[k] + 16'h0001 : cnt_pv[k];
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state      <= pscio_pkg::ST_IN_REFRESH;
      o_op_ready <= 1'b0;
    end else begin
      state      <= next_state;
      o_op_ready <= (next_state == pscio_pkg::ST_EXEC) && run_en && !op_end;
    end
  end

  // 10 ms tick and 100 ms units since the last end
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      tick_cnt <= 18'h0_0000;
      tick     <= 1'b0;
      div100   <= 4'h0;
      el100    <= 16'h0000;
    end else begin
      tick     <= (tick_cnt == TICK_LAST);
      tick_cnt <= (tick_cnt == TICK_LAST) ? 18'h0_0000 : tick_cnt + 18'h0_0001;
      if (tick) begin
        div100 <= (div100 == `PSCIO_TMR100_DIV) ? 4'h0 : div100 + 4'h1;
      end
      if (st_end) begin
        el100 <= 16'h0000;
      end else if (tick && div100 == `PSCIO_TMR100_DIV && el100 != `PSCIO_WORD_MAX) begin
        el100 <= el100 + 16'h0001;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      run_en <= `PSCIO_CTRL_RST;
      tmode  <= `PSCIO_TMODE_RST;
    end else begin
      if (wr_ctrl && rif.wr_strb[0]) begin
        run_en <= rif.wr_data[0];
      end
      if (wr_tmode) begin
        for (int b = 0; b < 4; b++) begin
          if (rif.wr_strb[b]) begin
            tmode[8*b +: 8] <= rif.wr_data[8*b +: 8];
          end
        end
      end
    end
  end

  // Images and relays
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      in_image   <= 64'h0000_0000_0000_0000;
      out_image  <= 64'h0000_0000_0000_0000;
      relay      <= 64'h0000_0000_0000_0000;
      o_term_out <= 7'h00;
    end else begin
      if (st_in) begin
        in_image <= {52'h0_0000_0000_0000, i_term_in};
      end
      if (op_take && i_op_code == pscio_pkg::OP_OUT_Y) begin
        out_image[bit_idx] <= i_op_bit;
      end
      if (op_take && i_op_code == pscio_pkg::OP_OUT_M) begin
        relay[bit_idx] <= i_op_bit;
      end
      if (st_out) begin
        o_term_out <= out_image[6:0];
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      for (int d = 0; d < `PSCIO_D_POINTS; d++) begin
        data_mem[d] <= 16'h0000;
      end
    end else if (op_take && i_op_code == pscio_pkg::OP_WR_D && d_ok) begin
      data_mem[i_op_addr] <= i_op_word;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      for (int k = 0; k < `PSCIO_TC_POINTS; k++) begin
        tmr_pv[k]  <= 16'h0000;
        tmr_set[k] <= 16'h0000;
        cnt_pv[k]  <= 16'h0000;
        cnt_set[k] <= 16'h0000;
      end
      tmr_coil <= 16'h0000;
      tmr_done <= 16'h0000;
      cnt_coil <= 16'h0000;
      cnt_prev <= 16'h0000;
      cnt_done <= 16'h0000;
    end else begin
      if (st_end) begin
        for (int k = 0; k < `PSCIO_TC_POINTS; k++) begin
          tmr_pv[k]   <= tmr_pv_next[k];
          tmr_done[k] <= pscio_reached(tmr_pv_next[k], tmr_set[k]);
          cnt_pv[k]   <= cnt_pv_next[k];
          cnt_done[k] <= pscio_reached(cnt_pv_next[k], cnt_set[k]);
        end
        cnt_prev <= cnt_coil;
      end
      if (op_take) begin
        case (i_op_code)
          pscio_pkg::OP_OUT_T: begin
            tmr_coil[tc_idx] <= i_op_bit;
            tmr_set[tc_idx]  <= {1'b0, i_op_word[14:0]};
          end
          pscio_pkg::OP_OUT_C: begin
            cnt_coil[tc_idx] <= i_op_bit;
            cnt_set[tc_idx]  <= {1'b0, i_op_word[14:0]};
          end
          pscio_pkg::OP_RST_T: begin
            tmr_pv[tc_idx]   <= 16'h0000;
            tmr_done[tc_idx] <= 1'b0;
          end
          pscio_pkg::OP_RST_C: begin
            cnt_pv[tc_idx]   <= 16'h0000;
            cnt_done[tc_idx] <= 1'b0;
          end
          default: begin
          end
        endcase
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_op_done <= 1'b0;
      o_op_bit  <= 1'b0;
      o_op_word <= 16'h0000;
      o_running <= 1'b0;
    end else begin
      o_op_done <= op_take;
      o_running <= run_en;
      if (op_take) begin
        o_op_bit  <= res_bit;
        o_op_word <= res_word;
      end
    end
  end
endmodule : pscio_top

// ===== test/pscio_chk.sv
// Port checker for the scan-cycle engine
`timescale 1ns/1ps
module pscio_chk (
  input wire logic       i_clk, i_nrst, i_axi_awvalid, o_axi_awready, i_axi_wvalid, o_axi_wready, o_axi_bvalid,
  input wire logic       i_axi_bready, i_axi_arvalid, o_axi_arready, o_axi_rvalid, i_op_valid, o_op_ready, o_op_done,
  input wire logic [3:0] i_op_code,
  input wire logic [6:0] o_term_out
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  wire take = i_op_valid && o_op_ready;
  sequence s_end_gap; ##[0:1] !o_op_ready ##[1:5] o_op_ready; endsequence
  property p_end_gap; take && i_op_code == 4'hF |=> s_end_gap; endproperty
  a_end_gap: assert property (p_end_gap) else $error("ready gap after end wrong");
  property p_out_hold; o_op_ready && $past(o_op_ready) |-> $stable(o_term_out); endproperty
  a_out_hold: assert property (p_out_hold) else $error("terminal moved in scan");
  property p_done; take |=> o_op_done; endproperty
  a_done: assert property (p_done) else $error("no done after take");
  property p_no_done; !take |=> !o_op_done; endproperty
  a_no_done: assert property (p_no_done) else $error("done without take");
  property p_wr_ans; i_axi_awvalid && o_axi_awready && i_axi_wvalid && o_axi_wready |-> ##2 o_axi_bvalid; endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("write answer late");
  property p_b_hold; o_axi_bvalid && !i_axi_bready |=> o_axi_bvalid; endproperty
  a_b_hold: assert property (p_b_hold) else $error("bvalid dropped");
  property p_rd_ans; i_axi_arvalid && o_axi_arready |-> ##[2:3] o_axi_rvalid; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
  property p_r_hold; o_axi_rvalid |-> !o_axi_arready; endproperty
  a_r_hold: assert property (p_r_hold) else $error("read taken during answer");
endmodule : pscio_chk
bind pscio_top pscio_chk pscio_chk_inst (.i_clk(i_clk), .i_nrst(i_nrst), .i_axi_awvalid(i_axi_awvalid),
  .o_axi_awready(o_axi_awready), .i_axi_wvalid(i_axi_wvalid), .o_axi_wready(o_axi_wready),
  .o_axi_bvalid(o_axi_bvalid), .i_axi_bready(i_axi_bready), .i_axi_arvalid(i_axi_arvalid),
  .o_axi_arready(o_axi_arready), .o_axi_rvalid(o_axi_rvalid), .i_op_valid(i_op_valid), .o_op_ready(o_op_ready),
  .o_op_done(o_op_done), .i_op_code(i_op_code), .o_term_out(o_term_out));

// ===== test/pscio_term_dev.sv
// Switches wired to the control input terminals
`timescale 1ns/1ps
module pscio_term_dev (
  input  wire logic        i_clk,
  input  wire logic [11:0] i_level,
  output logic      [11:0] o_in
);
  // Contacts settle one clock after being thrown
  initial o_in = 12'h000;
  always @(posedge i_clk) o_in <= i_level;
endmodule : pscio_term_dev

// ===== test/testbench.sv
// Self-checking bench for the scan-cycle engine
`timescale 1ns/1ps
module testbench;
  logic        clk = 0, nrst = 0, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0, opv = 0, opb = 0;
  logic [7:0]  awa = 0, ara = 0, opa = 0;
  logic [31:0] wd = 0, rd;
  logic [3:0]  opc = 0;
  logic [15:0] opw = 0;
  logic [15:0] vals [4] = '{16'h8000, 16'h7FFF, 16'hFFFF, 16'h0001};
  logic [11:0] lvl = 0;
  wire  [11:0] tin;
  wire         awr, wr, bv, arr, rv, rdy, obit, run;
  wire  [1:0]  br, rr;
  wire  [31:0] rdat;
  wire  [15:0] oword;
  wire  [6:0]  tout;
  int          n_fail = 0;
  int          checks_done = 0;
  always #25 clk = ~clk;
  pscio_term_dev pscio_term_dev_inst (.i_clk(clk), .i_level(lvl), .o_in(tin));
  pscio_top #(.TICK_CYCLES(20)) pscio_top_inst (.i_clk(clk), .i_nrst(nrst), .i_axi_awaddr(awa),
    .i_axi_awvalid(awv), .o_axi_awready(awr), .i_axi_wdata(wd), .i_axi_wstrb(4'hF), .i_axi_wvalid(wv),
    .o_axi_wready(wr), .o_axi_bvalid(bv), .o_axi_bresp(br), .i_axi_bready(bready), .i_axi_araddr(ara),
    .i_axi_arvalid(arv), .o_axi_arready(arr), .o_axi_rvalid(rv), .o_axi_rdata(rdat), .o_axi_rresp(rr),
    .i_axi_rready(rready), .i_term_in(tin), .o_term_out(tout), .i_op_valid(opv), .i_op_code(opc),
    .i_op_addr(opa), .i_op_bit(opb), .i_op_word(opw), .o_op_ready(rdy), .o_op_done(), .o_op_bit(obit),
    .o_op_word(oword), .o_running(run));
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s exp %h got %h", nm, exp, got);
    end
  endtask : chk
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1; bready <= 1'b1;
    fork
      begin do @(posedge clk); while (!awr); awv <= 1'b0; end
      begin do @(posedge clk); while (!wr); wv <= 1'b0; end
    join
    do @(posedge clk); while (!bv);
    bready <= 1'b0;
    chk("bresp", 32'(br), 32'(e));
  endtask : axw
  task automatic axr(input logic [7:0] a, input logic [1:0] e);
    ara <= a; arv <= 1'b1; rready <= 1'b1;
    do @(posedge clk); while (!arr);
    arv <= 1'b0;
    do @(posedge clk); while (!rv);
    rready <= 1'b0;
    rd = rdat;
    chk("rresp", 32'(rr), 32'(e));
  endtask : axr
  task automatic op(input logic [3:0] c, input logic [7:0] a, input logic b, input logic [15:0] w);
    opc <= c; opa <= a; opb <= b; opw <= w; opv <= 1'b1;
    do @(posedge clk); while (!rdy);
    opv <= 1'b0;
    @(posedge clk);
  endtask : op
  task automatic scan_end;
    op(pscio_pkg::OP_END, 8'h00, 1'b0, 16'h0000);
    repeat (2) @(posedge clk);
    do @(posedge clk); while (!rdy);
  endtask : scan_end
  task automatic copy_scan;
    op(pscio_pkg::OP_LD_X, 8'h00, 1'b0, 16'h0000);
    op(pscio_pkg::OP_OUT_Y, 8'h00, obit, 16'h0000);
    scan_end;
  endtask : copy_scan
  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict
  initial begin
    #1000000;
    n_fail++;
    give_verdict;
  end
  initial begin
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    axr(8'h00, 2'h0);
    chk("ctrl", rd, 32'h0000_0001);
    axw(8'h08, 32'h1234_5678, 2'h0);
    axr(8'h08, 2'h0);
    chk("tmode", rd, 32'h1234_5678);
    axw(8'h0C, 32'h0000_0009, 2'h0);
    axw(8'h20, 32'h0000_0001, 2'h2);
    axr(8'h22, 2'h2);
    chk("unmapped", rd, 32'h0000_0000);
    lvl <= 12'hA53;
    repeat (2) @(posedge clk);
    scan_end;
    lvl <= 12'h5AC;
    for (int k = 0; k < 13; k++) begin
      op(pscio_pkg::OP_LD_X, 8'(k), 1'b0, 16'h0000);
      chk("ld_x", 32'(obit), (32'h0000_0A53 >> k) & 32'h0000_0001);
    end
    axr(8'h18, 2'h0);
    chk("in_img", rd, 32'h0000_0A53);
    op(pscio_pkg::OP_OUT_Y, 8'h05, 1'b1, 16'h0000);
    op(pscio_pkg::OP_OUT_Y, 8'h3F, 1'b1, 16'h0000);
    op(pscio_pkg::OP_LD_Y, 8'h05, 1'b0, 16'h0000);
    chk("ld_y", 32'(obit), 32'h0000_0001);
    chk("out_hold", 32'(tout), 32'h0000_0000);
    scan_end;
    chk("out_refr", 32'(tout), 32'h0000_0020);
    axr(8'h1C, 2'h0);
    chk("out_term", rd, 32'h0000_0020);
    lvl <= 12'h5AD;
    copy_scan;
    chk("late_1", 32'(tout), 32'h0000_0020);
    copy_scan;
    chk("late_2", 32'(tout), 32'h0000_0021);
    repeat (100) @(posedge clk);
    scan_end;
    axr(8'h10, 2'h0);
    chk("present", 32'(rd >= 5 && rd <= 6), 32'h0000_0001);
    scan_end;
    axr(8'h0C, 2'h0);
    chk("minimum", 32'(rd <= 1), 32'h0000_0001);
    axr(8'h14, 2'h0);
    chk("maximum", 32'(rd >= 5 && rd <= 6), 32'h0000_0001);
    for (int k = 0; k < 4; k++) begin
      op(pscio_pkg::OP_WR_D, 8'(k * 53), 1'b0, vals[k]);
      op(pscio_pkg::OP_RD_D, 8'(k * 53), 1'b0, 16'h0000);
      chk("d_word", 32'(oword), 32'(vals[k]));
    end
    for (int k = 0; k < 4; k++) begin
      op(pscio_pkg::OP_OUT_C, 8'h00, !k[0], 16'h0002);
      scan_end;
    end
    op(pscio_pkg::OP_LD_C, 8'h00, 1'b0, 16'h0000);
    chk("counter", 32'(obit), 32'h0000_0001);
    axw(8'h00, 32'h0000_0000, 2'h0);
    lvl <= 12'h0F0;
    repeat (20) @(posedge clk);
    chk("stopped", 32'({run, rdy}), 32'h0000_0000);
    axr(8'h18, 2'h0);
    chk("stop_in", rd, 32'h0000_00F0);
    axw(8'h00, 32'h0000_0001, 2'h0);
    do @(posedge clk); while (!rdy);
    op(pscio_pkg::OP_OUT_M, 8'h07, 1'b1, 16'h0000);
    nrst <= 1'b0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    op(pscio_pkg::OP_LD_M, 8'h07, 1'b0, 16'h0000);
    chk("relay_clr", 32'(obit), 32'h0000_0000);
    give_verdict;
  end
endmodule : testbench
